// ===== verilog/point_monitor_pkg.sv
`default_nettype none
package point_monitor_pkg;
  // point numbering and widths
  localparam int NUM_POINTS = 48;
  localparam int PT_W = 6;
  localparam int ADDR_W = 8;
  localparam int CHECKSUM_POINT = 16;
  localparam int LOCAL_XFER_POINT = 45;
  localparam int FAULT_DETECTOR_POINT = 47;
  localparam int TRIP_BUS_POINT = 48;
  // timing: 1 ms tick, persistence in seconds
  localparam int CLK_PERIOD_NS = 8;
  localparam int TICK_NS = 1000000;
  localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
  localparam int PERSIST_S = 5;
  localparam int TICKS_PER_S = 1000;
  localparam int PERSIST_TICKS = PERSIST_S * TICKS_PER_S;
  // register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h08;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h0C;
  localparam logic [7:0] ABN_LO_OFS = 8'h10;
  localparam logic [7:0] ABN_HI_OFS = 8'h14;
  localparam logic [7:0] TRIP_LO_OFS = 8'h18;
  localparam logic [7:0] TRIP_HI_OFS = 8'h1C;
  // field positions and reset values
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_CLR_BIT = 1;
  localparam logic CTRL_EN_RESET = 1'b1;
  localparam int IRQ_W = 3;
  localparam int IRQ_ALARM_BIT = 0;
  localparam int IRQ_TRIP_BIT = 1;
  localparam int IRQ_SUPPLY_BIT = 2;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 3'h0;
  localparam int STAT_ALARM_BIT = 0;
  localparam int STAT_SUPPLY_BIT = 1;
  localparam int STAT_CNT_LSB = 8;
  localparam logic [7:0] TX_TERM = 8'h00;
  // front display stepping
  typedef enum logic {STEP_IDLE = 1'b0, STEP_SEEK = 1'b1} step_state_type;
  // serial answer sequencer
  typedef enum logic [1:0] {TX_IDLE = 2'b00, TX_SCAN = 2'b01, TX_SEND = 2'b10} tx_state_type;
endpackage
`default_nettype wire

// ===== verilog/point_scan_if.sv
`timescale 1ns/1ps
`default_nettype none
// carries the tick and abnormal flags to the timers and persisted flags back
interface point_scan_if #(parameter int N = 48);
  logic tick;
  logic [N-1:0] abnormal;
  logic [N-1:0] persisted;
  modport timer(input tick, input abnormal, output persisted);
  modport ctrl(output tick, output abnormal, input persisted);
endinterface
`default_nettype wire

// ===== verilog/point_persist.sv
`timescale 1ns/1ps
`default_nettype none
module point_persist #(
  parameter int N = point_monitor_pkg::NUM_POINTS,
  parameter int LIMIT = point_monitor_pkg::PERSIST_TICKS
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  point_scan_if.timer scan
);
  import point_monitor_pkg::*;
  localparam int CW = $clog2(LIMIT + 2);

  // refuse a LIMIT or N below 1
  if (LIMIT < 1 || N < 1) begin : g_bad
    $error("point_persist: bad LIMIT or N");
  end

  for (genvar g = 0; g < N; g++) begin : g_pt
    logic [CW-1:0] cnt_reg, cnt_next; // ticks spent abnormal
    logic hit_reg, hit_next; // held past the limit

    // next count: restart on normal, count ticks while abnormal
    always_comb begin
      cnt_next = cnt_reg;
      hit_next = hit_reg;
      // RULE10 restart on normal
      if (!scan.abnormal[g]) begin
        cnt_next = '0;
        hit_next = 1'b0;
      end else if (scan.tick && !hit_reg) begin
        // RULE1 strictly beyond limit
        if (cnt_reg == CW'(LIMIT)) begin
          hit_next = 1'b1;
        end else begin
          cnt_next = cnt_reg + CW'(1);
        end
      end
    end

    // register timer state
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        cnt_reg <= '0;
        hit_reg <= 1'b0;
      end else if (ce_i) begin
        cnt_reg <= cnt_next;
        hit_reg <= hit_next;
      end
    end

    assign scan.persisted[g] = hit_reg;

    a_timer_restart: assert property (@(posedge clk_i) disable iff (rst_i) // RULE10
      (ce_i && !scan.abnormal[g]) |=> (!hit_reg && cnt_reg == '0))
      else $error("timer did not restart on normal point");
  end
endmodule
`default_nettype wire

// ===== verilog/point_monitor_alarm.sv
// Our own choices: the Wishbone slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// RULE1 - point abnormal past persistence closes alarm
// RULE2 - alarm also lights stored data indicator
// RULE3 - step shows next abnormal point number
// RULE4 - serial request sends all abnormal numbers
// RULE5 - capture point states at each trip
// RULE6 - point 48 trip bus, abnormal high
// RULE7 - point 47 fault detector, abnormal high
// RULE8 - reported number is input index; 16 checksum
// RULE9 - supply fault disables monitor and panel
// RULE10 - persistence timer restarts when point normal
module point_monitor_alarm #(
  parameter int CYCLES_PER_TICK = point_monitor_pkg::TICK_CYCLES,
  parameter int PERSIST_TICKS = point_monitor_pkg::PERSIST_TICKS,
  parameter logic [point_monitor_pkg::NUM_POINTS-1:0] ABNORMAL_HIGH = '1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [point_monitor_pkg::NUM_POINTS-1:0] points_i,
  input wire logic checksum_err_i,
  input wire logic dc_fault_i,
  input wire logic view_trip_i,
  input wire logic step_i,
  input wire logic serial_req_i,
  input wire logic serial_trip_i,
  input wire logic tx_ready_i,
  output logic [7:0] tx_data_o,
  output logic tx_valid_o,
  output logic [point_monitor_pkg::PT_W-1:0] display_point_o,
  output logic display_on_o,
  output logic alarm_contact_o,
  output logic monitor_record_view_led_o,
  output logic irq_o,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [point_monitor_pkg::ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);
  import point_monitor_pkg::*;
  localparam int N = NUM_POINTS;
  localparam int TW = $clog2(CYCLES_PER_TICK);
  // polarity with trip bus and fault detector forced high
  localparam logic [N-1:0] POL = ABNORMAL_HIGH
    | (N'(1) << (TRIP_BUS_POINT - 1)) | (N'(1) << (FAULT_DETECTOR_POINT - 1));

  if (CYCLES_PER_TICK < 2 || PERSIST_TICKS < 1 || N > 63) begin : g_bad
    $error("point_monitor_alarm: unsupported parameter values");
  end

  point_scan_if #(.N(N)) scan ();

  point_persist #(.N(N), .LIMIT(PERSIST_TICKS)) u_persist (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .scan(scan)
  );

  // ---- pin synchronisers ----
  logic [N-1:0] pt_s1_reg, pt_s1_next, pt_reg, pt_next; // point levels
  logic [2:0] misc_s1_reg, misc_s1_next, misc_reg, misc_next; // dc, view, step
  logic step_old_reg, step_old_next; // step level one cycle back

  // two flops per pin; edge detect reads only the second
  always_comb begin
    pt_s1_next = points_i;
    pt_next = pt_s1_reg;
    misc_s1_next = {step_i, view_trip_i, dc_fault_i};
    misc_next = misc_s1_reg;
    step_old_next = misc_reg[2];
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pt_s1_reg <= '0;
      pt_reg <= '0;
      misc_s1_reg <= '0;
      misc_reg <= '0;
      step_old_reg <= 1'b0;
    end else if (ce_i) begin
      pt_s1_reg <= pt_s1_next;
      pt_reg <= pt_next;
      misc_s1_reg <= misc_s1_next;
      misc_reg <= misc_next;
      step_old_reg <= step_old_next;
    end
  end

  logic dc_bad; // supply fault seen
  logic view_trip; // trip data view selected
  logic step_edge; // one press of the step control
  assign dc_bad = misc_reg[0];
  assign view_trip = misc_reg[1];
  assign step_edge = misc_reg[2] && !step_old_reg;

  // ---- registers held by software ----
  logic ctrl_en_reg, ctrl_en_next; // monitor enable
  logic [IRQ_W-1:0] irq_stat_reg, irq_stat_next; // sticky events
  logic [IRQ_W-1:0] irq_mask_reg, irq_mask_next; // event enables
  logic active; // monitor running
  // RULE9 supply fault disables
  assign active = ctrl_en_reg && !dc_bad;

  // abnormal vector, point k on bit k-1
  logic [N-1:0] abn;
  always_comb begin
    // RULE6 trip bus high
    // RULE7 fault detector high
    abn = ~(pt_reg ^ POL);
    // RULE8 point 16 checksum
    abn[CHECKSUM_POINT-1] = checksum_err_i;
    if (!active) begin
      abn = '0;
    end
  end
  assign scan.abnormal = abn;

  // ---- 1 ms tick prescaler ----
  logic [TW-1:0] tick_cnt_reg, tick_cnt_next; // cycles in this tick
  logic tick_reg, tick_next; // one cycle per ms

  always_comb begin
    tick_cnt_next = tick_cnt_reg + TW'(1);
    tick_next = 1'b0;
    if (tick_cnt_reg == TW'(CYCLES_PER_TICK - 1)) begin
      tick_cnt_next = '0;
      tick_next = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_cnt_reg <= '0;
      tick_reg <= 1'b0;
    end else if (ce_i) begin
      tick_cnt_reg <= tick_cnt_next;
      tick_reg <= tick_next;
    end
  end
  assign scan.tick = tick_reg;

  // ---- alarm contact, indicator and trip record ----
  logic alarm_reg, alarm_next; // alarm contact closed
  logic led_reg, led_next; // stored data indicator
  logic trip_old_reg, trip_old_next; // trip bus one cycle back
  logic trip_edge; // trip bus went abnormal
  logic [N-1:0] trip_rec_reg, trip_rec_next; // point states at trip
  logic [7:0] trip_cnt_reg, trip_cnt_next; // trips recorded
  logic clr_trip; // software clears record
  assign trip_edge = abn[TRIP_BUS_POINT-1] && !trip_old_reg;

  always_comb begin
    // RULE1 alarm on persisted
    alarm_next = active && (|scan.persisted);
    // RULE2 indicator with alarm
    led_next = alarm_next;
    trip_old_next = abn[TRIP_BUS_POINT-1];
    trip_rec_next = trip_rec_reg;
    trip_cnt_next = trip_cnt_reg;
    if (clr_trip) begin
      trip_rec_next = '0;
      trip_cnt_next = '0;
    end
    // RULE5 capture on trip
    if (trip_edge) begin
      trip_rec_next = abn;
      trip_cnt_next = trip_cnt_reg + 8'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      alarm_reg <= 1'b0;
      led_reg <= 1'b0;
      trip_old_reg <= 1'b0;
      trip_rec_reg <= '0;
      trip_cnt_reg <= '0;
    end else if (ce_i) begin
      alarm_reg <= alarm_next;
      led_reg <= led_next;
      trip_old_reg <= trip_old_next;
      trip_rec_reg <= trip_rec_next;
      trip_cnt_reg <= trip_cnt_next;
    end
  end
  assign alarm_contact_o = alarm_reg;
  assign monitor_record_view_led_o = led_reg;

  // ---- front display stepping ----
  step_state_type step_reg, step_next; // seek state
  logic [PT_W-1:0] probe_reg, probe_next; // index under test
  logic [PT_W-1:0] left_reg, left_next; // indices still to test
  logic [PT_W-1:0] disp_reg, disp_next; // shown point number
  logic disp_on_reg, disp_on_next; // display lit
  logic [N-1:0] view_src; // vector the panel walks
  assign view_src = view_trip ? trip_rec_reg : scan.persisted;

  always_comb begin
    step_next = step_reg;
    probe_next = probe_reg;
    left_next = left_reg;
    disp_next = disp_reg;
    disp_on_next = disp_on_reg;
    unique case (step_reg)
      STEP_IDLE: begin
        // RULE3 step starts seek
        if (step_edge && active) begin
          step_next = STEP_SEEK;
          probe_next = (disp_on_reg && disp_reg != PT_W'(N)) ? disp_reg : '0;
          left_next = PT_W'(N);
        end
      end
      STEP_SEEK: begin
        if (left_reg == '0) begin
          // nothing abnormal: blank
          disp_on_next = 1'b0;
          step_next = STEP_IDLE;
        end else if (view_src[probe_reg]) begin
          // RULE8 number is index plus one
          disp_next = probe_reg + PT_W'(1);
          disp_on_next = 1'b1;
          step_next = STEP_IDLE;
        end else begin
          probe_next = (probe_reg == PT_W'(N - 1)) ? '0 : probe_reg + PT_W'(1);
          left_next = left_reg - PT_W'(1);
        end
      end
    endcase
    // RULE9 panel dark on fault
    if (!active) begin
      step_next = STEP_IDLE;
      disp_on_next = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      step_reg <= STEP_IDLE;
      probe_reg <= '0;
      left_reg <= '0;
      disp_reg <= '0;
      disp_on_reg <= 1'b0;
    end else if (ce_i) begin
      step_reg <= step_next;
      probe_reg <= probe_next;
      left_reg <= left_next;
      disp_reg <= disp_next;
      disp_on_reg <= disp_on_next;
    end
  end
  assign display_point_o = disp_reg;
  assign display_on_o = disp_on_reg;

  // ---- serial answer: numbers then terminator ----
  tx_state_type tx_reg, tx_next; // sequencer state
  logic [PT_W-1:0] idx_reg, idx_next; // index being scanned
  logic tx_trip_reg, tx_trip_next; // answer from trip record
  logic [7:0] txd_reg, txd_next; // byte offered
  logic txv_reg, txv_next; // byte valid
  logic [N-1:0] tx_src; // vector being reported
  assign tx_src = tx_trip_reg ? trip_rec_reg : scan.persisted;

  always_comb begin
    tx_next = tx_reg;
    idx_next = idx_reg;
    tx_trip_next = tx_trip_reg;
    txd_next = txd_reg;
    txv_next = txv_reg;
    unique case (tx_reg)
      TX_IDLE: begin
        // RULE4 request starts scan
        if (serial_req_i && active) begin
          tx_next = TX_SCAN;
          idx_next = '0;
          tx_trip_next = serial_trip_i;
        end
      end
      TX_SCAN: begin
        if (idx_reg == PT_W'(N)) begin
          txd_next = TX_TERM;
          txv_next = 1'b1;
          tx_next = TX_SEND;
        end else if (tx_src[idx_reg]) begin
          txd_next = 8'(idx_reg) + 8'h01;
          txv_next = 1'b1;
          tx_next = TX_SEND;
        end else begin
          idx_next = idx_reg + PT_W'(1);
        end
      end
      TX_SEND: begin
        if (tx_ready_i) begin
          txv_next = 1'b0;
          tx_next = (idx_reg == PT_W'(N)) ? TX_IDLE : TX_SCAN;
          idx_next = (idx_reg == PT_W'(N)) ? idx_reg : idx_reg + PT_W'(1);
        end
      end
      default: tx_next = TX_IDLE;
    endcase
    // RULE9 stop answering on fault
    if (!active && tx_reg != TX_SEND) begin
      tx_next = TX_IDLE;
      // a hit found in this cycle must not leave valid stuck high
      txv_next = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_reg <= TX_IDLE;
      idx_reg <= '0;
      tx_trip_reg <= 1'b0;
      txd_reg <= '0;
      txv_reg <= 1'b0;
    end else if (ce_i) begin
      tx_reg <= tx_next;
      idx_reg <= idx_next;
      tx_trip_reg <= tx_trip_next;
      txd_reg <= txd_next;
      txv_reg <= txv_next;
    end
  end
  assign tx_data_o = txd_reg;
  assign tx_valid_o = txv_reg;

  // ---- wishbone slave and interrupt ----
  logic ack_reg, ack_next; // one-cycle answer
  logic [31:0] dat_reg, dat_next; // read data
  logic irq_reg, irq_next; // interrupt level
  logic alarm_old_reg, alarm_old_next; // alarm one cycle back
  logic dc_old_reg, dc_old_next; // supply fault one cycle back
  logic take, wr; // request accepted, and is a write
  logic [IRQ_W-1:0] events; // this cycle's events
  assign take = wb_cyc_i && wb_stb_i && !ack_reg;
  assign wr = take && wb_we_i && wb_sel_i[0];
  assign clr_trip = wr && wb_adr_i == CTRL_OFS && wb_dat_i[CTRL_CLR_BIT];
  assign events = {dc_bad && !dc_old_reg, trip_edge, alarm_next && !alarm_old_reg};

  always_comb begin
    ack_next = take;
    dat_next = '0;
    ctrl_en_next = ctrl_en_reg;
    irq_mask_next = irq_mask_reg;
    irq_stat_next = irq_stat_reg;
    alarm_old_next = alarm_next;
    dc_old_next = dc_bad;
    if (wr && wb_adr_i == CTRL_OFS) begin
      ctrl_en_next = wb_dat_i[CTRL_EN_BIT];
    end
    if (wr && wb_adr_i == IRQ_MASK_OFS) begin
      irq_mask_next = wb_dat_i[IRQ_W-1:0];
    end
    if (wr && wb_adr_i == IRQ_STAT_OFS) begin
      irq_stat_next = irq_stat_reg & ~wb_dat_i[IRQ_W-1:0];
    end
    // a new event wins over a clear
    irq_stat_next = irq_stat_next | events;
    irq_next = |(irq_stat_next & irq_mask_next);
    if (take && !wb_we_i) begin
      unique case (wb_adr_i)
        CTRL_OFS: dat_next[CTRL_EN_BIT] = ctrl_en_reg;
        STATUS_OFS: begin
          dat_next[STAT_ALARM_BIT] = alarm_reg;
          dat_next[STAT_SUPPLY_BIT] = dc_bad;
          dat_next[STAT_CNT_LSB +: 8] = trip_cnt_reg;
        end
        IRQ_STAT_OFS: dat_next[IRQ_W-1:0] = irq_stat_reg;
        IRQ_MASK_OFS: dat_next[IRQ_W-1:0] = irq_mask_reg;
        ABN_LO_OFS: dat_next = abn[31:0];
        ABN_HI_OFS: dat_next[N-33:0] = abn[N-1:32];
        TRIP_LO_OFS: dat_next = trip_rec_reg[31:0];
        TRIP_HI_OFS: dat_next[N-33:0] = trip_rec_reg[N-1:32];
        default: dat_next = '0;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      dat_reg <= '0;
      ctrl_en_reg <= CTRL_EN_RESET;
      irq_mask_reg <= IRQ_MASK_RESET;
      irq_stat_reg <= '0;
      irq_reg <= 1'b0;
      alarm_old_reg <= 1'b0;
      dc_old_reg <= 1'b0;
    end else if (ce_i) begin
      ack_reg <= ack_next;
      dat_reg <= dat_next;
      ctrl_en_reg <= ctrl_en_next;
      irq_mask_reg <= irq_mask_next;
      irq_stat_reg <= irq_stat_next;
      irq_reg <= irq_next;
      alarm_old_reg <= alarm_old_next;
      dc_old_reg <= dc_old_next;
    end
  end
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;
  assign irq_o = irq_reg;

  // ---- checks ----
  sequence seq_scan_hit;
    active && tx_reg == TX_SCAN && idx_reg != PT_W'(N) && tx_src[idx_reg];
  endsequence
  sequence seq_seek_hit;
    active && step_reg == STEP_SEEK && left_reg != '0 && view_src[probe_reg];
  endsequence

  a_alarm_follows: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i) // RULE1
    (active && |scan.persisted) |=> alarm_contact_o)
    else $error("alarm not closed after persisted point");
  a_led_with_alarm: assert property (@(posedge clk_i) disable iff (rst_i) // RULE2
    alarm_contact_o == monitor_record_view_led_o)
    else $error("indicator differs from alarm");
  a_step_shows_point: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i) // RULE3
    seq_seek_hit |=> display_on_o && display_point_o == $past(probe_reg) + PT_W'(1))
    else $error("step did not show abnormal point");
  a_serial_number: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i) // RULE4
    seq_scan_hit |=> tx_valid_o && tx_data_o == 8'($past(idx_reg)) + 8'h01)
    else $error("serial byte not the abnormal number");
  a_trip_capture: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i) // RULE5
    (trip_edge && !clr_trip) |=> trip_rec_reg == $past(abn))
    else $error("trip record not captured");
  a_trip_bus_high: assert property (@(posedge clk_i) disable iff (rst_i) // RULE6
    active |-> abn[TRIP_BUS_POINT-1] == pt_reg[TRIP_BUS_POINT-1])
    else $error("trip bus polarity wrong");
  a_fault_detector_high: assert property (@(posedge clk_i) disable iff (rst_i) // RULE7
    active |-> abn[FAULT_DETECTOR_POINT-1] == pt_reg[FAULT_DETECTOR_POINT-1])
    else $error("fault detector polarity wrong");
  a_checksum_point: assert property (@(posedge clk_i) disable iff (rst_i) // RULE8
    active |-> abn[CHECKSUM_POINT-1] == checksum_err_i)
    else $error("point 16 not checksum error");
  a_supply_blanks: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i) // RULE9
    !active |=> !alarm_contact_o && !display_on_o)
    else $error("monitor active during supply fault");
endmodule
`default_nettype wire

// ===== bench/serial_terminal.sv
`timescale 1ns/1ps
`default_nettype none
// serial video terminal: takes offered bytes, stalling at random
module serial_terminal (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] tx_data_i,
  input wire logic tx_valid_i,
  output logic tx_ready_o
);
  // bytes received, in arrival order
  logic [7:0] rx_q[$];
  // a byte is taken at an edge where it is offered and we are ready
  always @(posedge clk_i) begin
    if (!rst_i && tx_valid_i === 1'b1 && tx_ready_o) begin
      rx_q.push_back(tx_data_i);
    end
    // ready in about three cycles of four, so the sender must hold
    tx_ready_o <= !rst_i && ($urandom_range(3) != 0);
  end
endmodule
`default_nettype wire

// ===== bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import point_monitor_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce = 1'b1;
  logic [47:0] points = '0;
  logic chk_err = 1'b0;
  logic dc_fault = 1'b0;
  logic view_trip = 1'b0;
  logic step = 1'b0;
  logic serial_req = 1'b0;
  logic serial_trip = 1'b0;
  logic wb_req = 1'b0;
  logic wb_we = 1'b0;
  logic [7:0] wb_adr = '0;
  logic [31:0] wb_dat = '0;
  logic tx_ready;
  logic [7:0] tx_data;
  logic tx_valid;
  logic [PT_W-1:0] display_point;
  logic display_on, alarm, led, irq, wb_ack;
  logic [31:0] wb_rdat;
  int fail_count = 0;
  int tests_run = 0;
  int cur = 0;
  // 125 MHz clock
  initial begin
    forever #4 clk_i = ~clk_i;
  end
  point_monitor_alarm #(.CYCLES_PER_TICK(4), .PERSIST_TICKS(3)) i_point_monitor_alarm (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .points_i(points),
    .checksum_err_i(chk_err), .dc_fault_i(dc_fault), .view_trip_i(view_trip),
    .step_i(step), .serial_req_i(serial_req), .serial_trip_i(serial_trip),
    .tx_ready_i(tx_ready), .tx_data_o(tx_data), .tx_valid_o(tx_valid),
    .display_point_o(display_point), .display_on_o(display_on),
    .alarm_contact_o(alarm), .monitor_record_view_led_o(led), .irq_o(irq),
    .wb_cyc_i(wb_req), .wb_stb_i(wb_req), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
    .wb_sel_i(4'hF), .wb_dat_i(wb_dat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack)
  );
  serial_terminal term (
    .clk_i(clk_i), .rst_i(rst_i), .tx_data_i(tx_data), .tx_valid_i(tx_valid),
    .tx_ready_o(tx_ready)
  );
  // verdict and end of run
  task automatic stop_test();
    if (fail_count == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // one comparison
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one classic wishbone cycle, waiting for ack under a bound
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd,
                    output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_req <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_dat <= wd;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack !== 1'b1 && n < 20);
    rd = wb_rdat;
    wb_req <= 1'b0;
    if (wb_ack !== 1'b1) begin
      fail_count++;
      stop_test();
    end
  endtask
  // next marked point after c, wrapping; 0 when none
  function automatic int next_pt(input int c, input logic [47:0] msk);
    int k;
    for (int i = 1; i <= 48; i++) begin
      k = ((c + i - 1) % 48) + 1;
      if (msk[k-1]) return k;
    end
    return 0;
  endfunction
  // request a report and compare the byte stream with the mask
  task automatic ser(input logic trip, input logic [47:0] msk);
    int n;
    int j;
    n = 0;
    j = 0;
    term.rx_q.delete();
    @(posedge clk_i);
    serial_req <= 1'b1;
    serial_trip <= trip;
    @(posedge clk_i);
    serial_req <= 1'b0;
    while ((term.rx_q.size() == 0 || term.rx_q[$] !== 8'h00) && n < 800) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 800) begin
      fail_count++;
      stop_test();
    end
    for (int k = 1; k <= 48; k++) begin
      if (msk[k-1]) begin
        chk(term.rx_q[j], k);
        j++;
      end
    end
    chk(term.rx_q.size(), j + 1);
  endtask
  // one press of the step control, then the shown number
  task automatic press(input logic [47:0] msk);
    @(posedge clk_i);
    step <= 1'b1;
    repeat (4) @(posedge clk_i);
    step <= 1'b0;
    repeat (60) @(posedge clk_i);
    cur = next_pt(cur, msk);
    chk(32'(display_point), cur);
    chk(32'(display_on), 1);
  endtask
  initial begin
    logic [31:0] r;
    logic [47:0] m;
    r = $urandom(32'h8B6A);
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, CTRL_OFS, 32'h0, r);
    chk(r, 32'h1);
    wb(1'b0, IRQ_MASK_OFS, 32'h0, r);
    chk(r, 32'h0);
    // interrupted abnormal intervals never reach the alarm
    repeat (5) begin
      @(posedge clk_i);
      points[2] <= 1'b1;
      repeat (8) @(posedge clk_i);
      points[2] <= 1'b0;
      repeat (3) @(posedge clk_i);
    end
    chk(alarm, 0);
    @(posedge clk_i);
    points[2] <= 1'b1;
    repeat (10) @(posedge clk_i);
    chk(alarm, 0);
    repeat (30) @(posedge clk_i);
    chk(alarm, 1);
    chk(led, 1);
    chk(irq, 0);
    wb(1'b1, IRQ_MASK_OFS, 32'h1, r);
    repeat (2) @(posedge clk_i);
    chk(irq, 1);
    wb(1'b1, IRQ_STAT_OFS, 32'h1, r);
    repeat (2) @(posedge clk_i);
    chk(irq, 0);
    // random abnormal set; point 16 comes from the checksum flag
    m = 48'({$urandom, $urandom});
    m[47:46] = 2'b00;
    m[2] = 1'b1;
    m[15] = 1'b1;
    points <= m & ~(48'h1 << 15);
    chk_err <= 1'b1;
    repeat (60) @(posedge clk_i);
    wb(1'b0, ABN_LO_OFS, 32'h0, r);
    chk(r, m[31:0]);
    wb(1'b0, ABN_HI_OFS, 32'h0, r);
    chk(r, {16'h0, m[47:32]});
    ser(1'b0, m);
    repeat (3) press(m);
    // trip bus and fault detector raised together
    m[47:46] = 2'b11;
    points[47:46] <= 2'b11;
    repeat (10) @(posedge clk_i);
    wb(1'b0, TRIP_HI_OFS, 32'h0, r);
    chk(r, {16'h0, m[47:32]});
    chk(r[14], 1);
    wb(1'b0, TRIP_LO_OFS, 32'h0, r);
    chk(r, m[31:0]);
    wb(1'b0, STATUS_OFS, 32'h0, r);
    chk(r[15:8], 1);
    wb(1'b0, IRQ_STAT_OFS, 32'h0, r);
    chk(r[IRQ_TRIP_BIT], 1);
    ser(1'b1, m);
    view_trip <= 1'b1;
    repeat (2) press(m);
    wb(1'b1, CTRL_OFS, 32'h3, r);
    wb(1'b0, TRIP_LO_OFS, 32'h0, r);
    chk(r, 0);
    // clock enable low freezes the alarm although points go normal
    ce <= 1'b0;
    points <= '0;
    chk_err <= 1'b0;
    repeat (20) @(posedge clk_i);
    chk(alarm, 1);
    ce <= 1'b1;
    repeat (20) @(posedge clk_i);
    chk(alarm, 0);
    points <= m & ~(48'h1 << 15);
    chk_err <= 1'b1;
    repeat (40) @(posedge clk_i);
    chk(alarm, 1);
    // supply fault silences monitor and panel
    dc_fault <= 1'b1;
    repeat (10) @(posedge clk_i);
    chk(alarm, 0);
    chk(display_on, 0);
    wb(1'b0, STATUS_OFS, 32'h0, r);
    chk(r[STAT_SUPPLY_BIT], 1);
    term.rx_q.delete();
    serial_req <= 1'b1;
    @(posedge clk_i);
    serial_req <= 1'b0;
    repeat (80) @(posedge clk_i);
    chk(term.rx_q.size(), 0);
    wb(1'b0, 8'h40, 32'h0, r);
    chk(r, 0);
    stop_test();
  end
endmodule
`default_nettype wire
